// >>> rtl/dfm_fifo.sv
/*
 * small valid/ready fifo, flip-flop storage.
 * assumes a single clock, synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module dfm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_b,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} dfm_fifo_s;
	dfm_fifo_s st;
	dfm_fifo_s next_st;
	logic      push;
	logic      pop;

	assign o_in_ready  = (st.cnt != (AW+1)'(DEPTH));
	assign o_out_valid = (st.cnt != '0);
	assign o_out_data  = st.mem[st.rp];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_comb
	begin
		next_st = st;
		if (push)
		begin
			next_st.mem[st.wp] = i_in_data;
			next_st.wp = st.wp + 1'b1;
		end
		if (pop)
			next_st.rp = st.rp + 1'b1;
		if (push && !pop)
			next_st.cnt = st.cnt + 1'b1;
		else if (pop && !push)
			next_st.cnt = st.cnt - 1'b1;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
			st <= '0;
		else
			st <= next_st;
	end
endmodule // dfm_fifo
`default_nettype wire

// >>> rtl/dfm_map.svh
/*
 * register offsets, field positions and constants of the disk format microsequencer.
 * assumes an 8-bit local register port with an 8-bit address.
 */
`ifndef DFM_MAP_SVH
`define DFM_MAP_SVH
`define DFM_REG_SECTOR_LEN   8'h4e
`define DFM_REG_MODE_CTRL    8'h4f
`define DFM_REG_OP_CTRL      8'h77
`define DFM_REG_BRANCH_ADDR  8'h78
`define DFM_REG_START_ADDR   8'h79
`define DFM_REG_SYNC_PATT    8'h7c
`define DFM_REG_CW_NEXT      8'h9f
`define DFM_REG_CW_CTRL      8'hbf
`define DFM_REG_CW_COUNT     8'hdf
`define DFM_REG_CW_BRANCH    8'hff
`define DFM_STOP_ADDR        5'h1f
`define DFM_WORDS            31
`define DFM_CTL_XFER         0
`define DFM_CTL_SPLIT        3
`define DFM_CTL_RGATE        4
`define DFM_CTL_WGATE        5
`define DFM_CTL_ECC          6
`define DFM_CTL_ALT          7
`define DFM_OP_INHIBIT       4
`define DFM_MODE_SPLIT_DIS   7
`define DFM_BR_SHIFT         5
`define DFM_FIFO_DEPTH       8
`define DFM_FIFO_WIDTH       8
`endif

// >>> rtl/dfm_pkg.sv
/*
 * types of the disk format microsequencer.
 * assumes nothing from dfm_map.svh; its numeric constants are its own.
 */
package dfm_pkg;
	typedef struct packed {
		logic [7:0] branch;
		logic [7:0] count;
		logic [7:0] ctrl;
		logic [7:0] next;
	} dfm_word_s;
	typedef enum logic [2:0] {
		DFM_IDLE = 3'b001,
		DFM_SYNC = 3'b010,
		DFM_RUN  = 3'b100
	} dfm_state_e;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} dfm_host_s;
endpackage

// >>> rtl/dfm_sequencer.sv
/*
 * disk format microsequencer: program store, current word, branch and count logic,
 * sector length counter, split field control and sync search, behind the local
 * register port. assumes one clock, host strobes and byte strobe synchronous to it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dfm_map.svh"

// Behaviour
// - program store holds 31 words of four bytes, the program
// - each word has next, control, count and branch byte fields
// - writing start address fetches that word and starts executing it
// - current word is 32 bits, fields readable and writable at own addresses
// - current word drives the disk operation and the read and write gate outputs
// - count decrements per data byte; underflow fetches next word
// - branch command from next field bits 7-5 plus control bit 7
// - next address from next field, branch field, branch register, or stop
// - fetching address 1fh halts; writing 1fh to start stops
// - transfer words count length minus one, 1 to 256 bytes
// - inhibit bit suppresses underflow advance of transfer words and decrements sector counter
// - sector counter underflow clears the inhibit bit
// - sector counter reloads from sector length before each data field
// - split disable clear makes control bit 3 soft stop ecc; a transfer word after a non-transfer word restarts it
// - sync pattern register is the searched sync character
// - disk input lines are sampled and steer branches
// - execution suspends during sync search until a match
// - sync search starts when read gate is first asserted
module dfm_sequencer (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_b,
	input  wire logic [7:0] i_host_addr,
	input  wire logic [7:0] i_host_wdata,
	input  wire logic       i_host_wr,
	input  wire logic       i_host_rd,
	output logic      [7:0] o_host_rdata,
	input  wire logic [3:0] i_disk_in,
	input  wire logic       i_byte_valid,
	input  wire logic [7:0] i_byte_data,
	output logic            o_byte_ready,
	output logic            o_data_valid,
	input  wire logic       i_data_ready,
	output logic      [7:0] o_data,
	output logic            o_read_gate,
	output logic            o_write_gate,
	output logic            o_ecc_active,
	output logic            o_running,
	output logic            o_sync_search
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [`DFM_WORDS-1:0][31:0] store;
		dfm_pkg::dfm_word_s          cw;
		dfm_pkg::dfm_state_e         fsm;
		logic [4:0]                  pc;
		logic [7:0]                  sector_len;
		logic [7:0]                  mode_ctrl;
		logic [7:0]                  op_ctrl;
		logic [7:0]                  branch_addr;
		logic [7:0]                  start_addr;
		logic [7:0]                  sync_patt;
		logic [7:0]                  sector_cnt;
		logic                        in_field;
		logic                        rgate_seen;
		logic                        ecc_on;
		logic [7:0]                  rdata;
		logic                        rgate;
		logic                        wgate;
		logic                        ecc_out;
		logic                        running;
		logic                        sync_out;
	} dfm_seq_s;
	dfm_seq_s st;
	dfm_seq_s next_st;

	dfm_pkg::dfm_host_s host;
	logic               fifo_in_ready;
	logic               byte_take;
	logic [4:0]         target;

	assign host.addr  = i_host_addr;
	assign host.wdata = i_host_wdata;
	assign host.wr    = i_host_wr;
	assign host.rd    = i_host_rd;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	// branch select
	function automatic logic [4:0] next_addr(
		input dfm_pkg::dfm_word_s w,
		input logic [3:0]         din,
		input logic [7:0]         br_reg
	);
		logic [2:0] cmd;
		logic       cond;
		logic [4:0] res;
		cmd  = w.next[7:`DFM_BR_SHIFT];
		cond = din[cmd[1:0]];
		res  = w.next[4:0];
		if (!w.ctrl[`DFM_CTL_ALT])
		begin
			case (cmd)
				3'h0: res = w.next[4:0];
				3'h1: res = cond ? w.branch[4:0] : w.next[4:0];
				3'h2: res = cond ? br_reg[4:0] : w.next[4:0];
				3'h3: res = cond ? `DFM_STOP_ADDR : w.next[4:0];
				3'h4: res = w.branch[4:0];
				3'h5: res = br_reg[4:0];
				3'h6: res = `DFM_STOP_ADDR;
				default: res = cond ? w.next[4:0] : w.branch[4:0];
			endcase
		end
		else
		begin
			// second jump set: commands 1-3 branch on inputs negated, 4-7 test disk lines 3-0
			case (cmd)
				3'h0: res = w.next[4:0];
				3'h1: res = !cond ? w.branch[4:0] : w.next[4:0];
				3'h2: res = !cond ? br_reg[4:0] : w.next[4:0];
				3'h3: res = !cond ? `DFM_STOP_ADDR : w.next[4:0];
				3'h4: res = din[3] ? w.branch[4:0] : br_reg[4:0];
				3'h5: res = din[2] ? w.branch[4:0] : br_reg[4:0];
				3'h6: res = din[1] ? `DFM_STOP_ADDR : w.branch[4:0];
				default: res = din[0] ? `DFM_STOP_ADDR : w.next[4:0];
			endcase
		end
		return res;
	endfunction

	function automatic dfm_pkg::dfm_word_s word_of(input logic [31:0] v);
		return dfm_pkg::dfm_word_s'(v);
	endfunction

	// ------------------------------------------------------------
	// data path buffer
	// ------------------------------------------------------------
	assign byte_take = i_byte_valid && fifo_in_ready && (st.fsm == dfm_pkg::DFM_RUN)
		&& st.cw.ctrl[`DFM_CTL_XFER];
	assign target    = next_addr(st.cw, i_disk_in, st.branch_addr);

	dfm_fifo #(
		.WIDTH(`DFM_FIFO_WIDTH),
		.DEPTH(`DFM_FIFO_DEPTH)
	) u_fifo (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_in_valid (byte_take),
		.o_in_ready (fifo_in_ready),
		.i_in_data  (i_byte_data),
		.o_out_valid(o_data_valid),
		.i_out_ready(i_data_ready),
		.o_out_data (o_data)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic       fetch;
		logic [4:0] faddr;
		logic       uflow;
		fetch   = 1'b0;
		faddr   = `DFM_STOP_ADDR;
		uflow   = 1'b0;
		next_st = st;

		// host writes
		if (host.wr)
		begin
			if (host.addr == `DFM_REG_SECTOR_LEN)
				next_st.sector_len = host.wdata;
			else if (host.addr == `DFM_REG_MODE_CTRL)
				next_st.mode_ctrl = host.wdata;
			else if (host.addr == `DFM_REG_OP_CTRL)
				next_st.op_ctrl = host.wdata;
			else if (host.addr == `DFM_REG_BRANCH_ADDR)
				next_st.branch_addr = host.wdata;
			else if (host.addr == `DFM_REG_SYNC_PATT)
				next_st.sync_patt = host.wdata;
			else if (host.addr == `DFM_REG_CW_NEXT)
				next_st.cw.next = host.wdata;
			else if (host.addr == `DFM_REG_CW_CTRL)
				next_st.cw.ctrl = host.wdata;
			else if (host.addr == `DFM_REG_CW_COUNT)
				next_st.cw.count = host.wdata;
			else if (host.addr == `DFM_REG_CW_BRANCH)
				next_st.cw.branch = host.wdata;
			else if (host.addr[7] == 1'b0 && host.addr[1:0] != 2'h3)
			begin
				// program store bytes at 0x00..0x7b, byte lane from low bits
				if (host.addr[6:2] != `DFM_STOP_ADDR)
					next_st.store[host.addr[6:2]][host.addr[1:0]*8 +: 8] = host.wdata;
			end
			if (host.addr[7] == 1'b0 && host.addr[1:0] == 2'h3
				&& host.addr[6:2] != `DFM_STOP_ADDR)
				next_st.store[host.addr[6:2]][31:24] = host.wdata;
		end

		// host reads
		next_st.rdata = 8'h00;
		if (host.rd)
		begin
			if (host.addr == `DFM_REG_SECTOR_LEN)
				next_st.rdata = st.sector_len;
			else if (host.addr == `DFM_REG_MODE_CTRL)
				next_st.rdata = st.mode_ctrl;
			else if (host.addr == `DFM_REG_OP_CTRL)
				next_st.rdata = st.op_ctrl;
			else if (host.addr == `DFM_REG_BRANCH_ADDR)
				next_st.rdata = st.branch_addr;
			else if (host.addr == `DFM_REG_START_ADDR)
				next_st.rdata = {3'h0, st.pc};
			else if (host.addr == `DFM_REG_SYNC_PATT)
				next_st.rdata = st.sync_patt;
			else if (host.addr == `DFM_REG_CW_NEXT)
				next_st.rdata = st.cw.next;
			else if (host.addr == `DFM_REG_CW_CTRL)
				next_st.rdata = st.cw.ctrl;
			else if (host.addr == `DFM_REG_CW_COUNT)
				next_st.rdata = st.cw.count;
			else if (host.addr == `DFM_REG_CW_BRANCH)
				next_st.rdata = st.cw.branch;
			else if (host.addr[7] == 1'b0 && host.addr[6:2] != `DFM_STOP_ADDR)
				next_st.rdata = st.store[host.addr[6:2]][host.addr[1:0]*8 +: 8];
		end

		// sequencing
		case (st.fsm)
			dfm_pkg::DFM_IDLE:
			begin
			end
			dfm_pkg::DFM_SYNC:
			begin
				if (i_byte_valid && i_byte_data == st.sync_patt)
					next_st.fsm = dfm_pkg::DFM_RUN;
			end
			default:
			begin
				if (!st.cw.ctrl[`DFM_CTL_XFER])
				begin
					// non-transfer word: one byte time per strobe
					if (i_byte_valid)
						uflow = 1'b1;
				end
				else if (byte_take)
					uflow = 1'b1;
				if (uflow)
				begin
					// count per byte, advance past zero
					next_st.cw.count = st.cw.count - 8'h01;
					if (st.cw.count == 8'h00)
					begin
						if (st.cw.ctrl[`DFM_CTL_XFER] && st.op_ctrl[`DFM_OP_INHIBIT])
						begin
							next_st.sector_cnt = st.sector_cnt - 8'h01;
							if (st.sector_cnt == 8'h00)
								next_st.op_ctrl[`DFM_OP_INHIBIT] = 1'b0;
						end
						else
						begin
							fetch = 1'b1;
							faddr = target;
						end
					end
				end
			end
		endcase

		// start address write fetches and runs
		if (host.wr && host.addr == `DFM_REG_START_ADDR)
		begin
			next_st.start_addr = host.wdata;
			fetch = 1'b1;
			faddr = host.wdata[4:0];
			next_st.rgate_seen = 1'b0;
		end

		if (fetch)
		begin
			next_st.pc = faddr;
			// leaving a transfer word: soft stop or ecc end
			if (st.cw.ctrl[`DFM_CTL_XFER] && (st.cw.ctrl[`DFM_CTL_ECC]
				|| (!st.mode_ctrl[`DFM_MODE_SPLIT_DIS] && st.cw.ctrl[`DFM_CTL_SPLIT])))
				next_st.ecc_on = 1'b0;
			if (faddr == `DFM_STOP_ADDR)
			begin
				next_st.fsm = dfm_pkg::DFM_IDLE;
				next_st.cw = '0;
				next_st.in_field = 1'b0;
				next_st.ecc_on = 1'b0;
			end
			else
			begin
				next_st.cw = word_of(st.store[faddr]);
				next_st.fsm = dfm_pkg::DFM_RUN;
				// first read gate starts sync search
				if (next_st.cw.ctrl[`DFM_CTL_RGATE] && !st.rgate_seen)
				begin
					next_st.rgate_seen = 1'b1;
					next_st.fsm = dfm_pkg::DFM_SYNC;
				end
				// reload sector counter at data field start
				if (next_st.cw.ctrl[`DFM_CTL_XFER] && !st.in_field)
					next_st.sector_cnt = st.sector_len;
				next_st.in_field = next_st.cw.ctrl[`DFM_CTL_XFER];
				// field start, plain or soft start, enables ecc
				if (next_st.cw.ctrl[`DFM_CTL_XFER]
					&& !(st.fsm != dfm_pkg::DFM_IDLE && st.cw.ctrl[`DFM_CTL_XFER]))
					next_st.ecc_on = 1'b1;
			end
		end

		next_st.rgate    = (next_st.fsm != dfm_pkg::DFM_IDLE) && next_st.cw.ctrl[`DFM_CTL_RGATE];
		next_st.wgate    = (next_st.fsm != dfm_pkg::DFM_IDLE) && next_st.cw.ctrl[`DFM_CTL_WGATE];
		next_st.ecc_out  = next_st.ecc_on;
		next_st.running  = (next_st.fsm != dfm_pkg::DFM_IDLE);
		next_st.sync_out = (next_st.fsm == dfm_pkg::DFM_SYNC);
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_b)
		begin
			st     <= '0;
			st.fsm <= dfm_pkg::DFM_IDLE;
			st.pc  <= `DFM_STOP_ADDR;
		end
		else
			st <= next_st;
	end

	assign o_host_rdata  = st.rdata;
	assign o_read_gate   = st.rgate;
	assign o_write_gate  = st.wgate;
	assign o_ecc_active  = st.ecc_out;
	assign o_running     = st.running;
	assign o_sync_search = st.sync_out;
	assign o_byte_ready  = fifo_in_ready;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_stop_halts;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(host.wr && host.addr == `DFM_REG_START_ADDR && host.wdata[4:0] == `DFM_STOP_ADDR)
			|=> (st.fsm == dfm_pkg::DFM_IDLE) && !o_read_gate && !o_write_gate;
	endproperty
	a_stop_halts: assert property (p_stop_halts)
		else $error("stop address did not halt");

	property p_start_loads;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(host.wr && host.addr == `DFM_REG_START_ADDR && host.wdata[4:0] != `DFM_STOP_ADDR)
			|=> st.cw == word_of($past(st.store[host.wdata[4:0]]));
	endproperty
	a_start_loads: assert property (p_start_loads)
		else $error("start write did not load word");

	property p_gate_follows;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		o_running |-> (o_write_gate == st.cw.ctrl[`DFM_CTL_WGATE]);
	endproperty
	a_gate_follows: assert property (p_gate_follows)
		else $error("write gate differs from control field");

	property p_sync_hold;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(st.fsm == dfm_pkg::DFM_SYNC && !(i_byte_valid && i_byte_data == st.sync_patt)
			&& !host.wr) |=> $stable(st.cw.count);
	endproperty
	a_sync_hold: assert property (p_sync_hold)
		else $error("count moved during sync search");

	property p_inhibit_clear;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(st.fsm == dfm_pkg::DFM_RUN && byte_take && st.cw.count == 8'h00
			&& st.op_ctrl[`DFM_OP_INHIBIT] && st.sector_cnt == 8'h00 && !host.wr)
			|=> !st.op_ctrl[`DFM_OP_INHIBIT] ##0 (st.cw.count == 8'hff);
	endproperty
	a_inhibit_clear: assert property (p_inhibit_clear)
		else $error("inhibit not cleared on sector underflow");

	property p_byte_count;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		(st.fsm == dfm_pkg::DFM_RUN && byte_take && st.cw.count != 8'h00 && !host.wr)
			|=> st.cw.count == 8'($past(st.cw.count) - 8'h01);
	endproperty
	a_byte_count: assert property (p_byte_count)
		else $error("count did not step once per byte");
endmodule // dfm_sequencer
`default_nettype wire

// >>> tb/dfm_disk_model.sv
/*
 * disk side model: byte times with data, disk input lines, drain of the byte stream.
 * assumes the sequencer's clock; the bench calls send and sets stall and o_disk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module dfm_disk_model (
	input  wire logic       i_core_clk,
	input  wire logic       i_byte_ready,
	output logic            o_byte_valid,
	output logic      [7:0] o_byte_data,
	output logic      [3:0] o_disk_in,
	output logic            o_data_ready
);
	// 0 always ready, 1 random stalls, 2 held off
	int stall = 0;
	initial
	begin
		o_byte_valid = 1'b0;
		o_byte_data = 8'h00;
		o_disk_in = 4'h0;
		o_data_ready = 1'b1;
	end
	// ------------------------------------------------------------
	// drain side
	// ------------------------------------------------------------
	always @(posedge i_core_clk)
		o_data_ready <= (stall == 2) ? 1'b0 : (stall == 1) ? 1'($urandom_range(1)) : 1'b1;
	// ------------------------------------------------------------
	// one byte time, held until taken
	// ------------------------------------------------------------
	task automatic send(input logic [7:0] b);
		int n;
		n = 0;
		@(posedge i_core_clk);
		o_byte_valid <= 1'b1;
		o_byte_data <= b;
		do
			@(posedge i_core_clk);
		while (i_byte_ready !== 1'b1 && ++n < 2000);
		o_byte_valid <= 1'b0;
		// released line shows the inverse, never a stale copy
		o_byte_data <= ~b;
	endtask
endmodule // dfm_disk_model
`default_nettype wire

// >>> tb/disk_format_microsequencer_tb.sv
/*
 * self-checking bench of the disk format microsequencer with a disk side model.
 * assumes dfm_map.svh on the include path and dfm_disk_model compiled before.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dfm_map.svh"
module disk_format_microsequencer_tb;
	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] rdata, bdata, dout, r, q;
	logic [3:0] din;
	logic       bvalid, bready, dvalid, dready, rgate, wgate, ecc, run, srch;
	logic [7:0] expq[$];
	logic [7:0] ra[4] = '{`DFM_REG_SECTOR_LEN, `DFM_REG_MODE_CTRL, `DFM_REG_BRANCH_ADDR,
		`DFM_REG_SYNC_PATT};
	int         num_errors = 0;
	int         samples_checked = 0;
	int         cycles = 0;
	int         t;

	always #4 clk = ~clk;

	dfm_sequencer DUT (
		.i_core_clk(clk), .i_rst_b(rst_b), .i_host_addr(addr), .i_host_wdata(wdata),
		.i_host_wr(wr), .i_host_rd(rd), .o_host_rdata(rdata), .i_disk_in(din),
		.i_byte_valid(bvalid), .i_byte_data(bdata), .o_byte_ready(bready),
		.o_data_valid(dvalid), .i_data_ready(dready), .o_data(dout), .o_read_gate(rgate),
		.o_write_gate(wgate), .o_ecc_active(ecc), .o_running(run), .o_sync_search(srch)
	);

	dfm_disk_model DISK (
		.i_core_clk(clk), .i_byte_ready(bready), .o_byte_valid(bvalid),
		.o_byte_data(bdata), .o_disk_in(din), .o_data_ready(dready)
	);

	// ------------------------------------------------------------
	// compares and closing
	// ------------------------------------------------------------
	task automatic chk_byte(input logic [7:0] got, exp, input string m);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, exp, input string m);
		chk_byte({7'h00, got}, {7'h00, exp}, m);
	endtask
	task automatic conclude();
		if (num_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			num_errors++;
			$display("CHECK FAILED %0t run did not finish", $time);
			conclude();
		end
	end
	// ------------------------------------------------------------
	// host register port and reference helpers
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wreg(input logic [7:0] a, d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic creg(input logic [7:0] a, exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk_byte(rdata, exp, "register read");
	endtask
	task automatic wword(input int w, input logic [7:0] n, c, k, b);
		wreg(8'(w * 4), n);
		wreg(8'(w * 4 + 1), c);
		wreg(8'(w * 4 + 2), k);
		wreg(8'(w * 4 + 3), b);
	endtask
	task automatic xfer(input int n);
		logic [7:0] v;
		repeat (n)
		begin
			v = 8'($urandom);
			expq.push_back(v);
			DISK.send(v);
		end
	endtask
	task automatic drain();
		int n;
		n = 0;
		while (expq.size() != 0 && n++ < 3000)
			@(posedge clk);
		tick(2);
		chk_flag(dvalid, 1'b0, "stream not empty");
	endtask
	function automatic int target(int c, int a, logic [3:0] d);
		logic hit;
		hit = d[c[1:0]] ^ a[0];
		case (c)
			0: return 1;
			1: return hit ? 2 : 1;
			2: return hit ? 3 : 1;
			3: return hit ? 31 : 1;
			4: return 2;
			5: return 3;
			default: return 31;
		endcase
	endfunction
	// every byte that leaves the stream is checked in order
	always @(posedge clk)
		if (dvalid === 1'b1 && dready === 1'b1)
		begin
			q = (expq.size() != 0) ? expq.pop_front() : ~dout;
			chk_byte(dout, q, "stream byte");
		end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(32'hab1f));
		tick(4);
		rst_b <= 1'b1;
		tick(1);
		chk_flag(run, 1'b0, "idle after reset");
		chk_flag(wgate | rgate, 1'b0, "gates after reset");
		foreach (ra[i])
		begin
			t = $urandom;
			wreg(ra[i], 8'(t));
			creg(ra[i], 8'(t));
		end
		wreg(8'h47, 8'h5e);
		creg(8'h47, 8'h5e);
		creg(8'ha0, 8'h00);
		wreg(`DFM_REG_OP_CTRL, 8'h00);
		// gate word then a 12 byte transfer word
		wword(0, 8'h01, 8'h20, 8'h03, 8'h00);
		wword(1, 8'h1f, 8'h21, 8'd11, 8'h00);
		DISK.stall = 2;
		wreg(`DFM_REG_START_ADDR, 8'h00);
		tick(2);
		chk_flag(run, 1'b1, "running");
		chk_flag(wgate & ~rgate, 1'b1, "write gate");
		creg(`DFM_REG_CW_CTRL, 8'h20);
		creg(`DFM_REG_CW_COUNT, 8'h03);
		repeat (3) DISK.send(8'h00);
		tick(3);
		creg(`DFM_REG_CW_COUNT, 8'h00);
		chk_flag(wgate, 1'b1, "gate held");
		DISK.send(8'h00);
		tick(3);
		creg(`DFM_REG_CW_CTRL, 8'h21);
		xfer(8);
		tick(2);
		chk_flag(bready, 1'b0, "buffer full");
		DISK.stall = 1;
		xfer(4);
		drain();
		chk_flag(run | wgate, 1'b0, "stopped");
		// branch commands against disk lines
		wreg(`DFM_REG_BRANCH_ADDR, 8'h03);
		wword(1, 8'hc0, 8'h00, 8'h21, 8'h00);
		wword(2, 8'hc0, 8'h00, 8'h22, 8'h00);
		wword(3, 8'hc0, 8'h00, 8'h23, 8'h00);
		for (int c = 0; c < 7; c++)
			for (int a = 0; a < 2; a++)
			begin
				if (a == 1 && (c == 0 || c > 3))
					continue;
				t = $urandom_range(15);
				DISK.o_disk_in <= 4'(t);
				wword(0, {3'(c), 5'h01}, {1'(a), 7'h00}, 8'h00, 8'h02);
				wreg(`DFM_REG_START_ADDR, 8'h00);
				tick(2);
				DISK.send(8'h5a);
				tick(3);
				t = target(c, a, 4'(t));
				if (t == 31)
					chk_flag(run, 1'b0, "branch to stop");
				else
					creg(`DFM_REG_CW_COUNT, 8'(32 + t));
				wreg(`DFM_REG_START_ADDR, 8'h1f);
			end
		// long field: one suppressed underflow, twice over
		wreg(`DFM_REG_SECTOR_LEN, 8'h00);
		wword(0, 8'h1f, 8'h01, 8'h02, 8'h00);
		for (int f = 0; f < 2; f++)
		begin
			wreg(`DFM_REG_OP_CTRL, 8'h10);
			wreg(`DFM_REG_START_ADDR, 8'h00);
			xfer(258);
			tick(3);
			chk_flag(run, 1'b1, "carry held");
			xfer(1);
			tick(3);
			chk_flag(run, 1'b0, "field done");
			creg(`DFM_REG_OP_CTRL, 8'h00);
			drain();
		end
		// split field: soft stop, gap, soft start, ecc end
		DISK.stall = 0;
		wreg(`DFM_REG_MODE_CTRL, 8'h00);
		wword(0, 8'h01, 8'h29, 8'h01, 8'h00);
		wword(1, 8'h02, 8'h28, 8'h00, 8'h00);
		wword(2, 8'h03, 8'h08, 8'h00, 8'h00);
		wword(3, 8'h1f, 8'h61, 8'h01, 8'h00);
		wreg(`DFM_REG_START_ADDR, 8'h00);
		tick(2);
		chk_flag(ecc, 1'b1, "ecc on in first part");
		xfer(2);
		tick(3);
		chk_flag(ecc, 1'b0, "soft stop");
		DISK.send(8'h00);
		tick(3);
		creg(`DFM_REG_CW_CTRL, 8'h08);
		DISK.send(8'h00);
		tick(3);
		chk_flag(ecc, 1'b1, "soft start");
		xfer(2);
		tick(3);
		chk_flag(ecc | run, 1'b0, "ecc end");
		drain();
		// sync search on read gate
		wreg(`DFM_REG_SYNC_PATT, 8'h3c);
		wword(0, 8'h1f, 8'h10, 8'h00, 8'h00);
		wreg(`DFM_REG_START_ADDR, 8'h00);
		tick(3);
		chk_flag(srch & rgate, 1'b1, "search on read gate");
		repeat (3) DISK.send(8'hc3);
		tick(3);
		chk_flag(srch & run, 1'b1, "suspended");
		DISK.send(8'h3c);
		tick(3);
		chk_flag(srch, 1'b0, "pattern found");
		wreg(`DFM_REG_START_ADDR, 8'h1f);
		tick(2);
		chk_flag(run | rgate, 1'b0, "host stop");
		conclude();
	end
endmodule // disk_format_microsequencer_tb
`default_nettype wire
